// file: rtl/dsl_params.svh
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH

`define DSL_WORD_BITS 16
`define DSL_ZERO_CODE 16'h0000
`define DSL_MID_CODE 16'h8000
`define DSL_RES_16 5'd16
`define DSL_RES_14 5'd14
`define DSL_RES_12 5'd12

`endif

// file: rtl/dsl_pkg.sv
package dsl_pkg;
    typedef logic [15:0] dsl_word_t;
    typedef enum logic {dsl_clr_zero, dsl_clr_mid} dsl_clr_e;
    typedef enum {dsl_idle, dsl_frame} dsl_state_e;
endpackage

// file: rtl/dsl_sync.sv
`timescale 1ns/1ns
module dsl_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // async in, synced out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    if (WIDTH < 1) begin : g_bad_width
        $error("sync width must be at least one");
    end

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    // reset levels: select, clock, data high
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= '1;
            dout <= '1;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule

// file: rtl/dsl_load_port.sv
// Contract
// - low select lets clock shift data in
// - select rise latches word, updates output
// - sample data on rising serial clock only
// - zero variant: clear forces latch to 0
// - bipolar variant: clear forces midscale code
// - shift msb first, in at bit 0 toward bit 15
// - short frame gives invalid word; resend
// - long frame keeps last 16 bits
// - short codes left-justified; pad bits ignored
`timescale 1ns/1ns
`include "dsl_params.svh"
module dsl_load_port #(
    parameter dsl_pkg::dsl_clr_e CLEAR_MODE = dsl_pkg::dsl_clr_zero,
    parameter int RESOLUTION = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // serial pins
    input wire logic frame_sel_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    // clear pin
    input wire logic async_clear_n,
    // converter side
    output dsl_pkg::dsl_word_t dac_code,
    output logic dac_update,
    output logic frame_short
);
    // refuse resolutions the pad mask cannot serve
    if (RESOLUTION != `DSL_RES_16 && RESOLUTION != `DSL_RES_14 &&
        RESOLUTION != `DSL_RES_12) begin : g_bad_res
        $error("unsupported resolution");
    end

    localparam dsl_pkg::dsl_word_t PAD_MASK =
        dsl_pkg::dsl_word_t'({`DSL_WORD_BITS{1'b1}} <<
        (`DSL_WORD_BITS - RESOLUTION));
    localparam dsl_pkg::dsl_word_t CLEAR_CODE =
        (CLEAR_MODE == dsl_pkg::dsl_clr_mid) ? `DSL_MID_CODE
                                             : `DSL_ZERO_CODE;

    function automatic dsl_pkg::dsl_word_t trim(input dsl_pkg::dsl_word_t w);
        trim = w & PAD_MASK;
    endfunction

    logic [2:0] pins;
    logic sel_n_s;
    logic sclk_s;
    logic din_s;
    dsl_sync #(.WIDTH(3)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .din({frame_sel_n, serial_clk, serial_din}),
        .dout(pins)
    );
    assign {sel_n_s, sclk_s, din_s} = pins;

    dsl_pkg::dsl_state_e state;
    dsl_pkg::dsl_state_e next_state;
    dsl_pkg::dsl_word_t shreg;
    dsl_pkg::dsl_word_t next_shreg;
    logic [4:0] count;
    logic [4:0] next_count;
    logic sclk_d;
    logic next_sclk_d;
    logic next_update;
    logic next_short;
    dsl_pkg::dsl_word_t next_code;
    logic sclk_rise;

    // clear path: async set of latch
    logic clr_s1;
    logic clr_held;
    logic next_clr_s1;
    logic next_clr_held;

    // release re-timed so the latch never leaves clear mid-cycle
    always_comb begin
        next_clr_s1 = 1'b0;
        next_clr_held = clr_s1;
    end

    always_ff @(posedge clock or negedge async_clear_n) begin
        if (!async_clear_n) begin
            clr_s1 <= 1'b1;
            clr_held <= 1'b1;
        end else begin
            clr_s1 <= next_clr_s1;
            clr_held <= next_clr_held;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_count = count;
        next_sclk_d = sclk_s;
        next_update = 1'b0;
        next_short = frame_short;
        next_code = dac_code;
        unique case (state)
            dsl_pkg::dsl_idle: begin
                if (!sel_n_s) begin
                    next_state = dsl_pkg::dsl_frame;
                    next_count = 5'd0;
                end
            end
            dsl_pkg::dsl_frame: begin
                if (sel_n_s) begin
                    next_state = dsl_pkg::dsl_idle;
                    next_code = trim(shreg);
                    next_update = 1'b1;
                    next_short = (count < `DSL_RES_16);
                end else if (sclk_rise) begin
                    next_shreg = {shreg[14:0], din_s};
                    if (count < `DSL_RES_16)
                        next_count = count + 5'd1;
                end
            end
        endcase
        if (clr_held) begin
            next_code = CLEAR_CODE;
            next_update = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= dsl_pkg::dsl_idle;
            shreg <= '0;
            count <= 5'd0;
            sclk_d <= 1'b1;
            dac_update <= 1'b0;
            frame_short <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            count <= next_count;
            sclk_d <= next_sclk_d;
            dac_update <= next_update;
            frame_short <= next_short;
        end
    end

    // latch: reset and clear both load the clear code at once
    logic latch_rst_n;
    assign latch_rst_n = arst_n & async_clear_n;
    always_ff @(posedge clock or negedge latch_rst_n) begin
        if (!latch_rst_n)
            dac_code <= CLEAR_CODE;
        else
            dac_code <= next_code;
    end

    a_clear_code: assert property (
        @(posedge clock) disable iff (!arst_n)
        !async_clear_n |-> dac_code == CLEAR_CODE)
        else $error("clear did not force latch code");
    a_zero_code: assert property (
        @(posedge clock) disable iff (!arst_n)
        clr_held && CLEAR_MODE == dsl_pkg::dsl_clr_zero
        |-> dac_code == `DSL_ZERO_CODE)
        else $error("zero variant clear code wrong");
    a_mid_code: assert property (
        @(posedge clock) disable iff (!arst_n)
        clr_held && CLEAR_MODE == dsl_pkg::dsl_clr_mid
        |-> dac_code == `DSL_MID_CODE)
        else $error("bipolar variant clear code wrong");
    a_clear_quiet: assert property (
        @(posedge clock) disable iff (!arst_n)
        clr_held |=> !dac_update)
        else $error("update pulse during clear");

    sequence s_frame_open;
        state == dsl_pkg::dsl_idle && !sel_n_s;
    endsequence
    sequence s_bit_taken;
        state == dsl_pkg::dsl_frame && !sel_n_s && sclk_rise;
    endsequence
    sequence s_sel_rise;
        state == dsl_pkg::dsl_frame && sel_n_s && !clr_held;
    endsequence

    a_frame_open: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_frame_open |=> state == dsl_pkg::dsl_frame && count == 5'd0)
        else $error("frame did not open on select low");
    a_load_word: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_sel_rise |=> dac_update && dac_code == trim($past(shreg)))
        else $error("word not latched on select rise");
    a_frame_close: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_sel_rise |=> state == dsl_pkg::dsl_idle)
        else $error("frame still open after select rise");
    a_update_pulse: assert property (
        @(posedge clock) disable iff (!arst_n)
        dac_update |=> !dac_update)
        else $error("update pulse longer than one cycle");
    a_code_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        $changed(dac_code) |-> dac_update || clr_held || !async_clear_n)
        else $error("latch changed without load or clear");
    a_shift_msb: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_bit_taken |=> shreg == {$past(shreg[14:0]), $past(din_s)})
        else $error("shift not msb first");
    a_idle_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == dsl_pkg::dsl_idle |=> shreg == $past(shreg))
        else $error("shift outside frame");
    a_no_fall: assert property (
        @(posedge clock) disable iff (!arst_n)
        !sclk_rise |=> shreg == $past(shreg))
        else $error("shift without rising edge");
    a_short_flag: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_sel_rise |=> frame_short == ($past(count) < 5'd16))
        else $error("short frame flag wrong");
    a_short_hold: assert property (
        @(posedge clock) disable iff (!arst_n)
        state == dsl_pkg::dsl_idle |=> $stable(frame_short))
        else $error("short frame flag moved between frames");
    a_pad_zero: assert property (
        @(posedge clock) disable iff (!arst_n)
        (dac_code & ~PAD_MASK) == 16'h0000)
        else $error("pad bits reached latch");
    a_count_cap: assert property (
        @(posedge clock) disable iff (!arst_n)
        count <= 5'd16)
        else $error("bit count overran");
    a_bit_count: assert property (
        @(posedge clock) disable iff (!arst_n)
        s_bit_taken ##0 count < 5'd16 |=> count == $past(count) + 5'd1)
        else $error("rising edge not counted");
endmodule

// file: tb/dsl_host_model.sv
`timescale 1ns/1ns
module dsl_host_model (
    // system clock
    input wire logic clock,
    // serial pins
    output logic frame_sel_n = 1'b1,
    output logic serial_clk = 1'b0,
    output logic serial_din = 1'b0
);
    // link clock idles low between frames; 8 system cycles per bit
    task automatic send(input logic [31:0] bits, input int n);
        @(negedge clock) frame_sel_n <= 1'b0;
        repeat (4) @(negedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            serial_din <= bits[i];
            repeat (4) @(negedge clock);
            serial_clk <= 1'b1;
            repeat (4) @(negedge clock);
            serial_clk <= 1'b0;
        end
        repeat (4) @(negedge clock);
        frame_sel_n <= 1'b1;
        serial_din <= ~serial_din;
    endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic async_clear_n = 1'b1;
    localparam int TIMEOUT = 6000;
    logic sel_n, sclk, sdin, upd_a, upd_b, short_a, short_b;
    dsl_pkg::dsl_word_t code_a, code_b, got_a, got_b;
    int fail_count = 0;
    int samples_checked = 0;
    int ups = 0;
    int ups_b = 0;
    int cycles = 0;
    int model = 0;
    logic [31:0] lfsr = 32'h68a68830;
    always #20 clock = ~clock;
    dsl_host_model host (.clock(clock), .frame_sel_n(sel_n),
        .serial_clk(sclk), .serial_din(sdin));
    dsl_load_port #(.CLEAR_MODE(dsl_pkg::dsl_clr_zero)) DUT (
        .clock(clock), .arst_n(arst_n), .frame_sel_n(sel_n),
        .serial_clk(sclk), .serial_din(sdin),
        .async_clear_n(async_clear_n), .dac_code(code_a),
        .dac_update(upd_a), .frame_short(short_a));
    dsl_load_port #(.CLEAR_MODE(dsl_pkg::dsl_clr_mid), .RESOLUTION(12))
        dut_mid (.clock(clock), .arst_n(arst_n), .frame_sel_n(sel_n),
        .serial_clk(sclk), .serial_din(sdin),
        .async_clear_n(async_clear_n), .dac_code(code_b),
        .dac_update(upd_b), .frame_short(short_b));
    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // outputs looked at mid-cycle, away from the edge that launches them
    always @(negedge clock) begin
        cycles++;
        if (upd_a === 1'b1) begin
            got_a = code_a;
            ups++;
        end
        if (upd_b === 1'b1) begin
            got_b = code_b;
            ups_b++;
        end
        if (cycles == TIMEOUT) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic frame(input int n);
        int u;
        int v;
        int bitq[$];
        lfsr = lfsr_next(lfsr);
        u = ups;
        v = ups_b;
        for (int i = n - 1; i >= 0; i--) begin
            bitq.push_back(int'(lfsr[i]));
        end
        host.send(lfsr, n);
        repeat (8) @(negedge clock);
        // model: msb first, only the last 16 bits survive
        while (bitq.size() > 0) begin
            model = ((model << 1) | bitq.pop_front()) & 32'hffff;
        end
        check("updates", 16'(ups - u), 16'h0001);
        check("updates12", 16'(ups_b - v), 16'h0001);
        check("short", {15'h0, short_a}, {15'h0, n < 16});
        check("short12", {15'h0, short_b}, {15'h0, n < 16});
        if (n >= 16) begin
            check("code16", got_a, 16'(model));
            check("code12", got_b, 16'(model) & 16'hfff0);
        end
    endtask
    task automatic clear_check();
        check("clr zero", code_a, 16'h0000);
        check("clr mid", code_b, 16'h8000);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        arst_n = 1'b1;
        clear_check();
        for (int i = 0; i < 6; i++) frame(16);
        frame(20);
        frame(10);
        // mid-run reset: latch back to clear code, status cleared
        arst_n = 1'b0;
        #1 clear_check();
        check("short reset", {15'h0, short_a}, 16'h0000);
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        frame(16);
        @(negedge clock) async_clear_n = 1'b0;
        #1 clear_check();
        repeat (3) @(negedge clock);
        async_clear_n = 1'b1;
        repeat (4) @(negedge clock);
        clear_check();
        frame(16);
        stop_test();
    end
endmodule
